/* rom_patch_params.svh */
// Constants for the ROM fetch patch unit
`ifndef ROM_PATCH_PARAMS_SVH
`define ROM_PATCH_PARAMS_SVH

`define PATCH_CHANNELS 4
`define PATCH_ADDR_W 32
`define PATCH_ADDR_MASK 32'h000ffffe
`define PATCH_ADDR_RESET 32'h00000000
`define PATCH_ENABLE_RESET 8'h00
`define PATCH_ENABLE_MASK 8'h0f
`define DEBUG_TRAP_VECTOR 32'h00000060
`define DEBUG_TRAP_OPCODE_DEFAULT 32'h0000f840
`define REG_PATCH_ADDRESS_0 6'h00
`define REG_PATCH_ADDRESS_1 6'h04
`define REG_PATCH_ADDRESS_2 6'h08
`define REG_PATCH_ADDRESS_3 6'h0c
`define REG_PATCH_ENABLE_CONTROL 6'h10
`define REG_UNMAPPED_READ 32'h00000000

`endif

/* rom_patch_pkg.sv */
// Types for the ROM fetch patch unit
package rom_patch_pkg;

    typedef struct packed {
        logic [5:0] address;
        logic read;
        logic write;
        logic [3:0] byteenable;
        logic [31:0] writedata;
    } avalon_req_t;

    typedef struct packed {
        logic [31:0] readdata;
        logic waitrequest;
    } avalon_rsp_t;

    typedef struct packed {
        logic valid;
        logic [31:0] address;
    } fetch_req_t;

    typedef struct packed {
        logic valid;
        logic [31:0] data;
    } fetch_rsp_t;

    typedef enum logic [1:0] {
        BUS_IDLE = 2'b00,
        BUS_ACK = 2'b01
    } bus_state_t;

endpackage : rom_patch_pkg

/* patch_match.sv */
// Comparator bank that flags a fetch hitting an enabled patch address
`timescale 1ns/1ps
`default_nettype none
`include "rom_patch_params.svh"

module patch_match
(
    input wire logic [`PATCH_CHANNELS*32-1:0] patch_addresses,
    input wire logic [`PATCH_CHANNELS-1:0] channel_enables,
    input wire logic [31:0] fetch_address,
    output logic hit
);

    logic [`PATCH_CHANNELS-1:0] ch_hit;

    // ------------------------------------------------------------
    // Per-channel compare
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `PATCH_CHANNELS; gi = gi + 1)
        begin : g_cmp
            assign ch_hit[gi] = channel_enables[gi] &&
                (patch_addresses[gi*32 +: 32] == fetch_address);
        end
    endgenerate

    assign hit = |ch_hit;

endmodule : patch_match
`default_nettype wire

/* rom_fetch_patch_unit.sv */
// ROM fetch patch unit: register file and fetch substitution
//
// Summary of operation
// - Four independent patch address registers each hold a code address to replace.
// - Each patch address is a 32-bit word whose halves are also writable alone as 16-bit lanes.
// - Reset clears every patch address register to zero.
// - Bit 0 and bits 20 to 31 of each patch address always read as zero.
// - The enable control register holds one enable per channel in bits 3 to 0, bits 7 to 4 read zero.
// - The enable control register allows byte access, bit access by read-modify-write, and resets to 00h.
// - A fetch at an enabled patch address returns the debug trap opcode instead of ROM code.
// - The debug trap opcode sends the CPU to the fixed vector 00000060h.
// - Only an instruction fetch with fetch_valid high at an enabled patch address returns the trap opcode.
//
// Register access over Avalon-MM and the register offsets are this design's own decisions.
`timescale 1ns/1ps
`default_nettype none
`include "rom_patch_params.svh"

module rom_fetch_patch_unit
#(
    parameter logic [31:0] DEBUG_TRAP_OPCODE = `DEBUG_TRAP_OPCODE_DEFAULT
)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [3:0] avs_byteenable,
    input wire logic [31:0] avs_writedata,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic fetch_valid,
    input wire logic [31:0] fetch_address,
    input wire logic [31:0] rom_data,
    output logic [31:0] fetch_data,
    output logic fetch_patched,
    output logic [31:0] trap_vector
);

    rom_patch_pkg::avalon_req_t req;
    rom_patch_pkg::bus_state_t state_ff;
    rom_patch_pkg::bus_state_t nxt_state;
    logic [31:0] addr_ff [`PATCH_CHANNELS];
    logic [31:0] nxt_addr [`PATCH_CHANNELS];
    logic [7:0] enable_ff;
    logic [7:0] nxt_enable;
    logic [31:0] readdata_ff;
    logic [31:0] nxt_readdata;
    logic [`PATCH_CHANNELS*32-1:0] addr_flat;
    logic hit;
    logic [31:0] lane_mask;
    logic access;

    assign req.address = avs_address;
    assign req.read = avs_read;
    assign req.write = avs_write;
    assign req.byteenable = avs_byteenable;
    assign req.writedata = avs_writedata;

    // ------------------------------------------------------------
    // Bus handshake: one wait cycle, acknowledge in second
    // ------------------------------------------------------------
    assign access = req.read || req.write;
    assign avs_waitrequest = access && (state_ff != rom_patch_pkg::BUS_ACK);

    always_comb
    begin
        nxt_state = rom_patch_pkg::BUS_IDLE;
        if (access && state_ff == rom_patch_pkg::BUS_IDLE)
        begin
            nxt_state = rom_patch_pkg::BUS_ACK;
        end
    end

    // ------------------------------------------------------------
    // Byte-lane mask
    // ------------------------------------------------------------
    always_comb
    begin
        lane_mask = {{8{req.byteenable[3]}}, {8{req.byteenable[2]}},
                     {8{req.byteenable[1]}}, {8{req.byteenable[0]}}};
    end

    // ------------------------------------------------------------
    // Register writes and read mux
    // ------------------------------------------------------------
    always_comb
    begin
        nxt_enable = enable_ff;
        nxt_readdata = readdata_ff;
        for (int i = 0; i < `PATCH_CHANNELS; i++)
        begin
            nxt_addr[i] = addr_ff[i];
        end
        if (req.write && state_ff == rom_patch_pkg::BUS_ACK)
        begin
            for (int i = 0; i < `PATCH_CHANNELS; i++)
            begin
                if (req.address == 6'(i * 4))
                begin
                    nxt_addr[i] = ((addr_ff[i] & ~lane_mask) | (req.writedata & lane_mask))
                        & `PATCH_ADDR_MASK;
                end
            end
            if (req.address == `REG_PATCH_ENABLE_CONTROL && req.byteenable[0])
            begin
                nxt_enable = req.writedata[7:0] & `PATCH_ENABLE_MASK;
            end
        end
        if (req.read && state_ff == rom_patch_pkg::BUS_IDLE)
        begin
            nxt_readdata = `REG_UNMAPPED_READ;
            unique case (req.address)
                `REG_PATCH_ADDRESS_0: nxt_readdata = addr_ff[0];
                `REG_PATCH_ADDRESS_1: nxt_readdata = addr_ff[1];
                `REG_PATCH_ADDRESS_2: nxt_readdata = addr_ff[2];
                `REG_PATCH_ADDRESS_3: nxt_readdata = addr_ff[3];
                `REG_PATCH_ENABLE_CONTROL: nxt_readdata = {24'h000000, enable_ff};
                default: nxt_readdata = `REG_UNMAPPED_READ;
            endcase
        end
    end

    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            state_ff <= rom_patch_pkg::BUS_IDLE;
            enable_ff <= `PATCH_ENABLE_RESET;
            readdata_ff <= 32'h00000000;
            for (int i = 0; i < `PATCH_CHANNELS; i++)
            begin
                addr_ff[i] <= `PATCH_ADDR_RESET;
            end
        end
        else
        begin
            state_ff <= nxt_state;
            enable_ff <= nxt_enable;
            readdata_ff <= nxt_readdata;
            for (int i = 0; i < `PATCH_CHANNELS; i++)
            begin
                addr_ff[i] <= nxt_addr[i];
            end
        end
    end

    assign avs_readdata = readdata_ff;

    // ------------------------------------------------------------
    // Fetch substitution, combinational so no delay is added
    // ------------------------------------------------------------
    genvar gi;
    generate
        for (gi = 0; gi < `PATCH_CHANNELS; gi = gi + 1)
        begin : g_flat
            assign addr_flat[gi*32 +: 32] = addr_ff[gi];
        end
    endgenerate

    patch_match u_match
    (
        .patch_addresses(addr_flat),
        .channel_enables(enable_ff[`PATCH_CHANNELS-1:0]),
        .fetch_address(fetch_address),
        .hit(hit)
    );

    assign fetch_patched = fetch_valid && hit;
    assign fetch_data = fetch_patched ? DEBUG_TRAP_OPCODE : rom_data;
    assign trap_vector = `DEBUG_TRAP_VECTOR;

endmodule : rom_fetch_patch_unit
`default_nettype wire

/* rom_model.sv */
// Program ROM model answering instruction fetches
`timescale 1ns/1ps
`default_nettype none
module rom_model
(
    input wire logic [31:0] fetch_address,
    output logic [31:0] rom_data
);
    // Code only, no trap handler lives here
    assign rom_data = {~fetch_address[15:0], fetch_address[15:0]};
endmodule : rom_model
`default_nettype wire

/* patch_assertions.sv */
// Checker for the ROM fetch patch unit
`timescale 1ns/1ps
`default_nettype none
module patch_chk #(parameter logic [31:0] DEBUG_TRAP_OPCODE = 32'h0)
(
    input wire logic clk,
    input wire logic nrst,
    input wire logic [5:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_readdata,
    input wire logic avs_waitrequest,
    input wire logic fetch_valid,
    input wire logic [31:0] rom_data,
    input wire logic [31:0] fetch_data,
    input wire logic fetch_patched,
    input wire logic [31:0] trap_vector
);
    default clocking @(posedge clk); endclocking
    default disable iff (!nrst);
    sequence acc_begin; $rose(avs_read || avs_write); endsequence
    sequence one_wait; avs_waitrequest ##1 !avs_waitrequest; endsequence
    trap_sub_a: assert property (fetch_patched |-> fetch_data == DEBUG_TRAP_OPCODE)
        else $error("trap opcode missing");
    pass_thru_a: assert property (!fetch_patched |-> fetch_data == rom_data)
        else $error("rom data altered");
    vector_fixed_a: assert property (trap_vector == 32'h00000060)
        else $error("trap vector wrong");
    access_wait_a: assert property (acc_begin |-> one_wait)
        else $error("wait cycle wrong");
    valid_gate_a: assert property (!fetch_valid |-> !fetch_patched)
        else $error("patch without access");
    addr_bits_a: assert property (avs_read && !avs_waitrequest && avs_address < 6'h10
        |-> avs_readdata[31:20] == 12'h000 && !avs_readdata[0]) else $error("address bits set");
    enable_bits_a: assert property (avs_read && !avs_waitrequest && avs_address == 6'h10
        |-> avs_readdata[31:4] == 28'h0) else $error("enable high bits set");
    reset_quiet_a: assert property ($rose(nrst) |-> !fetch_patched)
        else $error("patch after reset");
endmodule : patch_chk
bind rom_fetch_patch_unit patch_chk #(.DEBUG_TRAP_OPCODE(DEBUG_TRAP_OPCODE)) chk (.clk, .nrst,
    .avs_address, .avs_read, .avs_write, .avs_readdata, .avs_waitrequest, .fetch_valid, .rom_data,
    .fetch_data, .fetch_patched, .trap_vector);
`default_nettype wire

/* test_rom_fetch_patch_unit.sv */
// Testbench for the ROM fetch patch unit
`timescale 1ns/1ps
`default_nettype none
module test_rom_fetch_patch_unit;
    localparam logic [31:0] TRAP = 32'h00005a5a;
    logic clk = 0, nrst = 0, rd = 0, wr = 0, fv = 0, pat, wq;
    logic [5:0] adr = 6'h00;
    logic [3:0] be = 4'hf;
    logic [31:0] wd = 32'h0, fa = 32'h0, q, rq, rom, fd, tv;
    int errors = 0, check_count = 0;
    rom_model rm (.fetch_address(fa), .rom_data(rom));
    rom_fetch_patch_unit #(.DEBUG_TRAP_OPCODE(TRAP)) dut (.clk(clk), .nrst(nrst), .avs_address(adr),
        .avs_read(rd), .avs_write(wr), .avs_byteenable(be), .avs_writedata(wd), .avs_readdata(q),
        .avs_waitrequest(wq), .fetch_valid(fv), .fetch_address(fa), .rom_data(rom),
        .fetch_data(fd), .fetch_patched(pat), .trap_vector(tv));
    initial forever #5 clk = ~clk;
    task report_and_stop;
        $display("errors %0d checks %0d", errors, check_count);
        if (errors == 0 && check_count > 0)
            $display("STATUS OK");
        else
            $display("STATUS NOT OK");
        $finish;
    endtask : report_and_stop
    task cmp(input logic [31:0] got, input logic [31:0] exp);
        check_count++;
        if (got !== exp)
        begin
            errors++;
            $display("Error %0t got %h exp %h", $time, got, exp);
        end
    endtask : cmp
    task acc(input logic w, input logic [5:0] a, input logic [3:0] b, input logic [31:0] d);
        int n;
        n = 0;
        @(posedge clk);
        rd <= !w;
        wr <= w;
        adr <= a;
        be <= b;
        wd <= d;
        @(posedge clk);
        while (wq !== 1'b0)
        begin
            n++;
            if (n > 20)
            begin
                errors++;
                report_and_stop();
            end
            @(posedge clk);
        end
        rq = q;
        rd <= 1'b0;
        wr <= 1'b0;
    endtask : acc
    task rchk(input logic [5:0] a, input logic [31:0] exp);
        acc(1'b0, a, 4'hf, 32'h0);
        cmp(rq, exp);
    endtask : rchk
    task reset_vals;
        for (int i = 0; i < 5; i++)
            rchk(6'(i * 4), 32'h0);
        rchk(6'h14, 32'h0);
    endtask : reset_vals
    task addr_regs;
        acc(1'b1, 6'h00, 4'hf, 32'hffffffff);
        rchk(6'h00, 32'h000ffffe);
        acc(1'b1, 6'h04, 4'h3, 32'hffff1234);
        acc(1'b1, 6'h04, 4'hc, 32'h0005ffff);
        rchk(6'h04, 32'h00051234);
        for (int i = 0; i < 4; i++)
            acc(1'b1, 6'(i * 4), 4'hf, 32'h100 + i * 16);
        for (int i = 0; i < 4; i++)
            rchk(6'(i * 4), 32'h100 + i * 16);
    endtask : addr_regs
    task ctrl_reg;
        acc(1'b1, 6'h10, 4'h1, 32'hff);
        rchk(6'h10, 32'h0f);
        acc(1'b1, 6'h10, 4'h1, 32'h05);
        rchk(6'h10, 32'h05);
    endtask : ctrl_reg
    task fetch_chk(input logic v, input logic [31:0] a, input logic hit);
        @(posedge clk);
        fv <= v;
        fa <= a;
        @(negedge clk);
        cmp({31'h0, pat}, {31'h0, hit});
        cmp(fd, hit ? TRAP : {~a[15:0], a[15:0]});
        cmp(tv, 32'h00000060);
    endtask : fetch_chk
    task fetch_all;
        for (int i = 0; i < 4; i++)
            fetch_chk(1'b1, 32'h100 + i * 16, i % 2 == 0);
        fetch_chk(1'b1, 32'h102, 1'b0);
        fetch_chk(1'b1, 32'h104, 1'b0);
        fetch_chk(1'b0, 32'h100, 1'b0);
    endtask : fetch_all
    initial
    begin
        repeat (6) @(posedge clk);
        nrst <= 1'b1;
        reset_vals();
        addr_regs();
        ctrl_reg();
        fetch_all();
        report_and_stop();
    end
endmodule : test_rom_fetch_patch_unit
`default_nettype wire
